//--- src/msd_device.sv
// device end: command decoder and status response framer on the two-wire link
// assumes status inputs come from logic on CLK; pins pass a synchroniser
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
module msd_device (
  input wire logic CLK,
  input wire logic RST,
  msd_link_if.dev LINK,
  input wire logic [3:0] PROG_ADDR,
  input wire logic PIN_ADDR,
  input wire logic [3:0] RUN_CURRENT,
  input wire logic [3:0] HOLD_CURRENT,
  input wire logic [3:0] VMAX,
  input wire logic [3:0] VMIN,
  input wire logic NO_ACCEL_ENABLE,
  input wire logic [1:0] MICROSTEP_SELECT,
  input wire logic DIRECTION,
  input wire logic [3:0] ACCEL,
  input wire logic [1:0] TEMP_INFO,
  input wire logic [2:0] MOTION_STATUS,
  input wire logic EXTERNAL_SWITCH,
  input wire logic [msd_pkg::NUM_FLAGS-1:0] FLAG_EVENTS,
  input wire logic [15:0] ACTUAL_POSITION,
  input wire logic [15:0] TARGET_POSITION,
  input wire logic [10:0] SAFE_POSITION,
  output logic [msd_pkg::NUM_FLAGS-1:0] FLAGS,
  output logic ACTION_VALID,
  output logic [7:0] ACTION_CMD,
  output logic SDA_OE_N
);
  import msd_pkg::*;

  logic scl_s;
  logic sda_s;
  logic pin_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  msd_dev_state_t state_reg;
  msd_dev_state_t state_next;
  logic [3:0] bit_reg;
  logic [3:0] bit_next;
  logic [3:0] byte_reg;
  logic [3:0] byte_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;
  logic rw_reg;
  logic rw_next;
  logic mnack_reg;
  logic mnack_next;
  logic drv_reg;
  logic drv_next;
  logic act_reg;
  logic act_next;
  logic [NUM_FLAGS-1:0] flags_reg;
  logic [NUM_FLAGS-1:0] flags_next;
  logic [7:0] full_byte;
  logic [7:0] resp_byte;
  logic load;
  logic clear_lo;
  logic clear_hi;

  msd_sync u_scl (.clk(CLK), .rst(RST), .d(LINK.scl), .q(scl_s));
  msd_sync u_sda (.clk(CLK), .rst(RST), .d(LINK.sda), .q(sda_s));
  msd_sync u_pin (.clk(CLK), .rst(RST), .d(PIN_ADDR), .q(pin_s));

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_seen = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_seen = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign full_byte = {shift_reg[6:0], sda_s};
  assign LINK.dev_sda_o = 1'b0;
  assign LINK.dev_sda_oe_n = SDA_OE_N;

  // response byte for the device-sent index byte_reg
  always_comb begin
    resp_byte = FILL_BYTE;
    if (cmd_reg == FULL_STATUS_READ_CMD) begin
      case (byte_reg)
        4'h1: resp_byte = {ADDR2_FIXED_BITS, PROG_ADDR, pin_s};
        4'h2: resp_byte = {RUN_CURRENT, HOLD_CURRENT};
        4'h3: resp_byte = {VMAX, VMIN};
        4'h4: resp_byte = {NO_ACCEL_ENABLE, MICROSTEP_SELECT, DIRECTION, ACCEL};
        4'h5: resp_byte = {flags_reg[FLG_VDD], flags_reg[FLG_MISSED_STEP_FLAG], flags_reg[FLG_COIL_DEFECT_FLAG],
                           flags_reg[FLG_UV], flags_reg[FLG_TSD], flags_reg[FLG_TW],
                           TEMP_INFO};
        4'h6: resp_byte = {MOTION_STATUS, EXTERNAL_SWITCH, flags_reg[FLG_X_COIL_OVERCURRENT],
                           flags_reg[FLG_Y_COIL_OVERCURRENT], 1'b1, flags_reg[FLG_CP]};
        default: resp_byte = FILL_BYTE;
      endcase
    end else if (cmd_reg == POSITION_STATUS_READ_CMD) begin
      case (byte_reg)
        4'h1: resp_byte = {ADDR2_FIXED_BITS, PROG_ADDR, pin_s};
        4'h2: resp_byte = ACTUAL_POSITION[15:8];
        4'h3: resp_byte = ACTUAL_POSITION[7:0];
        4'h4: resp_byte = TARGET_POSITION[15:8];
        4'h5: resp_byte = TARGET_POSITION[7:0];
        4'h6: resp_byte = SAFE_POSITION[7:0];
        4'h7: resp_byte = {SAFE_HI_FILL, SAFE_POSITION[10:8]};
        default: resp_byte = FILL_BYTE;
      endcase
    end
  end

  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    byte_next = byte_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    cmd_next = cmd_reg;
    rw_next = rw_reg;
    mnack_next = mnack_reg;
    drv_next = drv_reg;
    act_next = 1'b0;
    load = 1'b0;
    if (start_seen) begin
      state_next = DS_RX;
      bit_next = 4'h0;
      byte_next = 4'h0;
      drv_next = 1'b0;
    end else if (stop_seen) begin
      state_next = DS_IDLE;
      drv_next = 1'b0;
    end else begin
      case (state_reg)
        DS_RX: begin
          if (scl_rise) begin
            shift_next = full_byte;
            bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'h7) begin
              bit_next = 4'h0;
              byte_next = byte_reg + 4'h1;
              state_next = DS_RX_END;
              if (byte_reg == 4'h0) begin
                rw_next = full_byte[0];
                if (full_byte[7:1] != {ADDR_FIXED_BITS, PROG_ADDR, pin_s} &&
                    !(full_byte[7:1] == GEN_CALL_ADDR && !full_byte[0])) begin
                  state_next = DS_IGNORE;
                end
              end else if (byte_reg >= MAX_BYTES) begin
                state_next = DS_IGNORE;
              end else if (byte_reg == 4'h1) begin
                cmd_next = full_byte;
                case (full_byte)
                  GOTO_SAFE_POS_CMD, IMMEDIATE_HALT_CMD, ZERO_POSITION_CMD,
                  RELOAD_DEFAULTS_CMD, TWO_STAGE_MOVE_CMD, MOTOR_CONFIG_CMD,
                  OTP_PROGRAM_CMD, TARGET_SET_CMD, DECEL_HALT_CMD: begin
                    act_next = 1'b1;
                  end
                  default: act_next = 1'b0;
                endcase
              end
            end
          end
        end
        DS_RX_END: begin
          if (scl_fall) begin
            drv_next = 1'b1;
            state_next = DS_RX_ACK;
          end
        end
        DS_RX_ACK: begin
          if (scl_fall) begin
            drv_next = 1'b0;
            state_next = DS_RX;
            load = rw_reg;
          end
        end
        DS_TX: begin
          if (scl_fall) begin
            if (bit_reg == BIT_ACK) begin
              drv_next = 1'b0;
              state_next = DS_TX_ACK;
            end else begin
              drv_next = ~tx_reg[7];
              tx_next = {tx_reg[6:0], 1'b1};
              bit_next = bit_reg + 4'h1;
            end
          end
        end
        DS_TX_ACK: begin
          if (scl_rise) begin
            mnack_next = sda_s;
          end
          if (scl_fall) begin
            if (mnack_reg) begin
              state_next = DS_IGNORE;
            end else begin
              load = 1'b1;
            end
          end
        end
        DS_IDLE, DS_IGNORE: begin
          drv_next = 1'b0;
        end
        default: begin
          state_next = DS_IDLE;
          drv_next = 1'b0;
        end
      endcase
    end
    if (load) begin
      drv_next = ~resp_byte[7];
      tx_next = {resp_byte[6:0], 1'b1};
      bit_next = 4'h1;
      byte_next = byte_reg + 4'h1;
      state_next = DS_TX;
    end
  end

  // each flag clears as the byte that reports it is captured; new events still win
  assign clear_lo = load && cmd_reg == FULL_STATUS_READ_CMD && byte_reg == 4'h5;
  assign clear_hi = load && cmd_reg == FULL_STATUS_READ_CMD && byte_reg == 4'h6;

  always_comb begin
    flags_next = (flags_reg & ~{{3{clear_hi}}, {6{clear_lo}}}) | FLAG_EVENTS;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= DS_IDLE;
      bit_reg <= 4'h0;
      byte_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'hFF;
      cmd_reg <= 8'h00;
      rw_reg <= 1'b0;
      mnack_reg <= 1'b1;
      drv_reg <= 1'b0;
      act_reg <= 1'b0;
      flags_reg <= '0;
      FLAGS <= '0;
      ACTION_VALID <= 1'b0;
      ACTION_CMD <= 8'h00;
      SDA_OE_N <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      state_reg <= state_next;
      bit_reg <= bit_next;
      byte_reg <= byte_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      cmd_reg <= cmd_next;
      rw_reg <= rw_next;
      mnack_reg <= mnack_next;
      drv_reg <= drv_next;
      act_reg <= act_next;
      flags_reg <= flags_next;
      FLAGS <= flags_next;
      ACTION_VALID <= act_next;
      ACTION_CMD <= cmd_next;
      SDA_OE_N <= ~drv_next;
    end
  end
endmodule

//--- src/msd_pkg.sv
// constants, types and field layout shared by both ends of the motor status link
// assumes a single 200 MHz clock per end and a pulled-up two-wire bus
package msd_pkg;
  localparam logic [7:0] FULL_STATUS_READ_CMD = 8'h81;
  localparam logic [7:0] POSITION_STATUS_READ_CMD = 8'hFC;
  localparam logic [7:0] OTP_PARAM_READ_CMD = 8'h82;
  localparam logic [7:0] GOTO_SAFE_POS_CMD = 8'h84;
  localparam logic [7:0] IMMEDIATE_HALT_CMD = 8'h85;
  localparam logic [7:0] ZERO_POSITION_CMD = 8'h86;
  localparam logic [7:0] RELOAD_DEFAULTS_CMD = 8'h87;
  localparam logic [7:0] TWO_STAGE_MOVE_CMD = 8'h88;
  localparam logic [7:0] MOTOR_CONFIG_CMD = 8'h89;
  localparam logic [7:0] OTP_PROGRAM_CMD = 8'h90;
  localparam logic [7:0] TARGET_SET_CMD = 8'h8B;
  localparam logic [7:0] DECEL_HALT_CMD = 8'h8F;

  localparam logic [1:0] ADDR_FIXED_BITS = 2'b11;
  localparam logic [2:0] ADDR2_FIXED_BITS = 3'b111;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [4:0] SAFE_HI_FILL = 5'h1F;
  localparam logic [3:0] MAX_BYTES = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h8;

  localparam int NUM_FLAGS = 9;
  localparam int FLG_TW = 0;
  localparam int FLG_TSD = 1;
  localparam int FLG_UV = 2;
  localparam int FLG_COIL_DEFECT_FLAG = 3;
  localparam int FLG_MISSED_STEP_FLAG = 4;
  localparam int FLG_VDD = 5;
  localparam int FLG_X_COIL_OVERCURRENT = 6;
  localparam int FLG_Y_COIL_OVERCURRENT = 7;
  localparam int FLG_CP = 8;

  localparam logic [7:0] REG_CMD_OFS = 8'h00;
  localparam logic [7:0] REG_TARGET_OFS = 8'h04;
  localparam logic [7:0] REG_STAT_OFS = 8'h08;
  localparam logic [7:0] REG_IRQ_OFS = 8'h0C;
  localparam logic [7:0] REG_MASK_OFS = 8'h10;
  localparam logic [2:0] REG_RX_PAGE = 3'h1;
  localparam int CMD_READ_POS = 8;
  localparam int TGT_PIN_POS = 4;
  localparam int TGT_GCALL_POS = 5;
  localparam int TGT_LSB_POS = 6;
  localparam int IRQ_DONE_POS = 0;
  localparam int IRQ_NACK_POS = 1;
  localparam logic [8:0] TARGET_RST = 9'h000;
  localparam logic [1:0] MASK_RST = 2'h0;

  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 400;
  localparam logic [7:0] SCL_QUARTER_CYC =
    8'((SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS));

  typedef enum logic [2:0] {
    DS_IDLE, DS_RX, DS_RX_END, DS_RX_ACK, DS_TX, DS_TX_ACK, DS_IGNORE
  } msd_dev_state_t;

  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} msd_host_state_t;
endpackage

//--- src/msd_link_if.sv
// two-wire link between controller and device
// assumes open-drain pins with a pull-up; enables are active low
`timescale 1ns/1ps
interface msd_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // wired-and with pull-up
  assign scl = scl_oe_n ? 1'b1 : scl_o;
  assign sda = (host_sda_oe_n ? 1'b1 : host_sda_o) & (dev_sda_oe_n ? 1'b1 : dev_sda_o);

  modport host (output scl_o, scl_oe_n, host_sda_o, host_sda_oe_n, input sda);
  modport dev (output dev_sda_o, dev_sda_oe_n, input scl, sda);
endinterface

//--- src/msd_sync.sv
// two flip-flop synchroniser for one pin
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module msd_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  logic meta_next;
  logic q_next;

  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_reg <= meta_next;
      q <= q_next;
    end
  end
endmodule

//--- src/msd_host.sv
// controller end: register port, clock divider and transfer sequencer
// assumes a single-cycle register master; bus pins pulled up
`timescale 1ns/1ps
module msd_host (
  input wire logic CLK,
  input wire logic RST,
  msd_link_if.host LINK,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic IRQ,
  output logic SCL_OE_N,
  output logic SDA_OE_N
);
  import msd_pkg::*;

  logic sda_s;
  msd_host_state_t st_reg;
  msd_host_state_t st_next;
  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic [1:0] q_reg;
  logic [1:0] q_next;
  logic [3:0] bit_reg;
  logic [3:0] bit_next;
  logic [3:0] byte_reg;
  logic [3:0] byte_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic rdx_reg;
  logic rdx_next;
  logic nack_reg;
  logic nack_next;
  logic scl_drv_reg;
  logic scl_drv_next;
  logic sda_drv_reg;
  logic sda_drv_next;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;
  logic rdreq_reg;
  logic rdreq_next;
  logic [8:0] tgt_reg;
  logic [8:0] tgt_next;
  logic [1:0] irq_reg;
  logic [1:0] irq_next;
  logic [1:0] mask_reg;
  logic [1:0] mask_next;
  logic [31:0] rdata_next;
  logic [7:0] rx_mem [8];
  logic [7:0] rx_next [8];
  logic tick;
  logic sending;
  logic [7:0] cur_byte;
  logic [7:0] keep_mask;
  logic [1:0] ev;

  msd_sync u_sda (.clk(CLK), .rst(RST), .d(LINK.sda), .q(sda_s));

  assign LINK.scl_o = 1'b0;
  assign LINK.host_sda_o = 1'b0;
  assign LINK.scl_oe_n = SCL_OE_N;
  assign LINK.host_sda_oe_n = SDA_OE_N;
  assign tick = (div_reg == SCL_QUARTER_CYC - 8'h01);
  assign sending = !rdx_reg || byte_reg == 4'h0;
  assign cur_byte = (byte_reg == 4'h0) ?
    (tgt_reg[TGT_GCALL_POS] && !rdx_reg ? {GEN_CALL_ADDR, 1'b0} :
     {ADDR_FIXED_BITS, tgt_reg[3:0], tgt_reg[TGT_PIN_POS], rdx_reg}) : cmd_reg;
  assign keep_mask = 8'hFF << tgt_reg[TGT_LSB_POS +: 3];

  always_comb begin
    st_next = st_reg;
    div_next = tick ? 8'h00 : div_reg + 8'h01;
    q_next = tick ? q_reg + 2'h1 : q_reg;
    bit_next = bit_reg;
    byte_next = byte_reg;
    sh_next = sh_reg;
    rdx_next = rdx_reg;
    nack_next = nack_reg;
    scl_drv_next = scl_drv_reg;
    sda_drv_next = sda_drv_reg;
    cmd_next = cmd_reg;
    rdreq_next = rdreq_reg;
    tgt_next = tgt_reg;
    mask_next = mask_reg;
    rx_next = rx_mem;
    ev = 2'h0;
    case (st_reg)
      HS_IDLE: begin
        div_next = 8'h00;
        q_next = 2'h0;
        if (WR && ADDR == REG_CMD_OFS) begin
          cmd_next = WDATA[7:0];
          rdreq_next = WDATA[CMD_READ_POS];
          rdx_next = 1'b0;
          nack_next = 1'b0;
          st_next = HS_START;
        end
      end
      HS_START: begin
        if (tick) begin
          case (q_reg)
            2'h0: begin
              scl_drv_next = 1'b0;
              sda_drv_next = 1'b0;
            end
            2'h1: sda_drv_next = 1'b1;
            2'h2: scl_drv_next = 1'b1;
            default: begin
              st_next = HS_BIT;
              bit_next = 4'h0;
              byte_next = 4'h0;
            end
          endcase
        end
      end
      HS_BIT: begin
        if (tick) begin
          case (q_reg)
            2'h0: begin
              if (bit_reg != BIT_ACK) begin
                sda_drv_next = sending && !cur_byte[3'(3'h7 - bit_reg[2:0])];
              end else begin
                sda_drv_next = !sending && byte_reg != MAX_BYTES;
              end
            end
            2'h1: scl_drv_next = 1'b0;
            2'h2: begin
              if (bit_reg != BIT_ACK && !sending) begin
                sh_next = {sh_reg[6:0], sda_s};
              end else if (bit_reg == BIT_ACK && sending) begin
                nack_next = sda_s;
              end
            end
            default: begin
              scl_drv_next = 1'b1;
              bit_next = bit_reg + 4'h1;
              if (bit_reg == BIT_ACK) begin
                bit_next = 4'h0;
                byte_next = byte_reg + 4'h1;
                if (!sending) begin
                  rx_next[3'(byte_reg - 4'h1)] =
                    ((cmd_reg == POSITION_STATUS_READ_CMD) &&
                     (byte_reg == 4'h3 || byte_reg == 4'h5)) ?
                    (sh_reg & keep_mask) : sh_reg;
                end
                if ((sending && nack_reg) || (rdx_reg && byte_reg == MAX_BYTES) ||
                    (!rdx_reg && byte_reg == 4'h1)) begin
                  st_next = HS_STOP;
                end
              end
            end
          endcase
        end
      end
      HS_STOP: begin
        if (tick) begin
          case (q_reg)
            2'h0: sda_drv_next = 1'b1;
            2'h1: scl_drv_next = 1'b0;
            2'h2: sda_drv_next = 1'b0;
            default: begin
              if (nack_reg) begin
                ev[IRQ_NACK_POS] = 1'b1;
                st_next = HS_IDLE;
              end else if (!rdx_reg && rdreq_reg && !tgt_reg[TGT_GCALL_POS]) begin
                rdx_next = 1'b1;
                st_next = HS_START;
              end else begin
                ev[IRQ_DONE_POS] = 1'b1;
                st_next = HS_IDLE;
              end
            end
          endcase
        end
      end
      default: st_next = HS_IDLE;
    endcase
    if (WR && ADDR == REG_TARGET_OFS) begin
      tgt_next = WDATA[8:0];
    end
    if (WR && ADDR == REG_MASK_OFS) begin
      mask_next = WDATA[1:0];
    end
    // event set wins over write-one clear
    irq_next = (irq_reg & ~((WR && ADDR == REG_IRQ_OFS) ? WDATA[1:0] : 2'h0)) | ev;
    rdata_next = 32'h0000_0000;
    if (RD) begin
      if (ADDR == REG_CMD_OFS) begin
        rdata_next = {23'h00_0000, rdreq_reg, cmd_reg};
      end else if (ADDR == REG_TARGET_OFS) begin
        rdata_next = {23'h00_0000, tgt_reg};
      end else if (ADDR == REG_STAT_OFS) begin
        rdata_next = {31'h0000_0000, st_reg != HS_IDLE};
      end else if (ADDR == REG_IRQ_OFS) begin
        rdata_next = {30'h0000_0000, irq_reg};
      end else if (ADDR == REG_MASK_OFS) begin
        rdata_next = {30'h0000_0000, mask_reg};
      end else if (ADDR[7:5] == REG_RX_PAGE) begin
        rdata_next = {24'h00_0000, rx_mem[ADDR[4:2]]};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_reg <= HS_IDLE;
      div_reg <= 8'h00;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      byte_reg <= 4'h0;
      sh_reg <= 8'h00;
      rdx_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_drv_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      cmd_reg <= 8'h00;
      rdreq_reg <= 1'b0;
      tgt_reg <= TARGET_RST;
      irq_reg <= 2'h0;
      mask_reg <= MASK_RST;
      rx_mem <= '{default: 8'h00};
      RDATA <= 32'h0000_0000;
      IRQ <= 1'b0;
      SCL_OE_N <= 1'b1;
      SDA_OE_N <= 1'b1;
    end else begin
      st_reg <= st_next;
      div_reg <= div_next;
      q_reg <= q_next;
      bit_reg <= bit_next;
      byte_reg <= byte_next;
      sh_reg <= sh_next;
      rdx_reg <= rdx_next;
      nack_reg <= nack_next;
      scl_drv_reg <= scl_drv_next;
      sda_drv_reg <= sda_drv_next;
      cmd_reg <= cmd_next;
      rdreq_reg <= rdreq_next;
      tgt_reg <= tgt_next;
      irq_reg <= irq_next;
      mask_reg <= mask_next;
      rx_mem <= rx_next;
      RDATA <= rdata_next;
      IRQ <= |(irq_reg & mask_reg);
      SCL_OE_N <= ~scl_drv_next;
      SDA_OE_N <= ~sda_drv_next;
    end
  end
endmodule

//--- sim/msd_link_assertions.sv
// checker for the wire level of the two-wire link
// assumes interface signals sampled on the shared CLK
`timescale 1ns/1ps
module msd_link_assertions (
  input wire logic CLK,
  input wire logic RST,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  property p_od; scl && !dev_sda_oe_n |-> host_sda_oe_n; endproperty
  a_od: assert property (p_od) else $error("both ends pull sda, clock high");
  property p_rel; $fell(RST) |-> scl_oe_n && host_sda_oe_n && dev_sda_oe_n; endproperty
  a_rel: assert property (p_rel) else $error("pin held after reset");
  property p_dchg; $changed(dev_sda_oe_n) |-> !scl; endproperty
  a_dchg: assert property (p_dchg) else $error("device moved sda, clock high");
  property p_hchg; $changed(host_sda_oe_n) && scl |-> dev_sda_oe_n; endproperty
  a_hchg: assert property (p_hchg) else $error("start or stop over device");
  property p_hi; $rose(scl) |-> scl [*8]; endproperty
  a_hi: assert property (p_hi) else $error("clock high too short");
  property p_lo; $fell(scl) |-> !scl [*8]; endproperty
  a_lo: assert property (p_lo) else $error("clock low too short");
  property p_start; scl && $fell(sda) |-> !host_sda_oe_n; endproperty
  a_start: assert property (p_start) else $error("start not by host");
  property p_stop; scl && $rose(sda) |-> scl [*8]; endproperty
  a_stop: assert property (p_stop) else $error("clock moved after stop");
  c_ack: cover property ($rose(scl) && !dev_sda_oe_n);
  c_start: cover property (scl && $fell(sda));
  c_stop: cover property (scl && $rose(sda));
endmodule

//--- sim/tb_motor_driver_status_command_decoder.sv
// bench: controller and device joined over the link
// assumes 200 MHz CLK and the controller register map
`timescale 1ns/1ps
module tb_motor_driver_status_command_decoder;
  import msd_pkg::*;
  localparam logic [3:0] PA = 4'hA;
  localparam logic PIN = 1'b1;
  localparam logic [7:0] SA = {3'b111, PA, PIN};
  localparam logic [7:0] WA = {2'b11, PA, PIN, 1'b0};
  localparam logic [15:0] ACT = 16'hF123;
  localparam logic [15:0] TGT = 16'h0ABC;
  localparam logic [10:0] SAFE = 11'h5A3;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic [8:0] ev = 9'h000;
  logic [8:0] flags;
  logic av;
  logic [7:0] acmd;
  logic [31:0] f = 32'h3C96_A55D;
  logic [7:0] sh = 8'h00;
  logic [7:0] fb = 8'h00;
  logic ps = 1'b1;
  logic pc = 1'b1;
  logic [7:0] last_act = 8'h00;
  int nb = 0;
  int n_act = 0;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #2.5 CLK = ~CLK;
  msd_link_if link ();
  msd_host u_msd_host (.CLK(CLK), .RST(RST), .LINK(link.host), .ADDR(adr), .WDATA(wd),
    .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .SCL_OE_N(), .SDA_OE_N());
  msd_device u_msd_device (.CLK(CLK), .RST(RST), .LINK(link.dev), .PROG_ADDR(PA),
    .PIN_ADDR(PIN), .RUN_CURRENT(f[31:28]), .HOLD_CURRENT(f[27:24]), .VMAX(f[23:20]),
    .VMIN(f[19:16]), .NO_ACCEL_ENABLE(f[15]), .MICROSTEP_SELECT(f[14:13]),
    .DIRECTION(f[12]), .ACCEL(f[11:8]), .TEMP_INFO(f[7:6]), .MOTION_STATUS(f[5:3]),
    .EXTERNAL_SWITCH(f[2]), .FLAG_EVENTS(ev), .ACTUAL_POSITION(ACT),
    .TARGET_POSITION(TGT), .SAFE_POSITION(SAFE), .FLAGS(flags), .ACTION_VALID(av),
    .ACTION_CMD(acmd), .SDA_OE_N());
  msd_link_assertions u_chk (.CLK(CLK), .RST(RST), .scl_o(link.scl_o),
    .scl_oe_n(link.scl_oe_n), .host_sda_o(link.host_sda_o),
    .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe_n(link.dev_sda_oe_n), .scl(link.scl), .sda(link.sda));
  // first byte after each start, shifted in at clock rise
  always @(posedge CLK) begin
    ps <= link.sda;
    pc <= link.scl;
    if (link.scl && ps && !link.sda) begin
      nb <= 0;
    end else if (link.scl && !pc && nb < 8) begin
      sh <= {sh[6:0], link.sda};
      nb <= nb + 1;
    end
    if (nb == 8) begin
      fb <= sh;
    end
    if (av === 1'b1) begin
      n_act <= n_act + 1;
      last_act <= acmd;
    end
  end
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge CLK);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    adr <= a;
    rd <= 1'b1;
    @(posedge CLK);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic [31:0] tw(input logic [2:0] n, input logic g);
    return {23'h0, n, g, PIN, PA};
  endfunction
  task automatic xfer(input logic [8:0] c);
    logic [31:0] s;
    wrr(REG_CMD_OFS, {23'h0, c});
    for (int i = 0; i < 6000; i++) begin
      rdr(REG_STAT_OFS, s);
      if (s[0] === 1'b0) return;
    end
    n_mismatch++;
    end_sim();
  endtask
  task automatic chk_rx(input logic [63:0] e);
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      rdr(8'(8'h20 + 4 * i), d);
      chk(d, {24'h0, e[63 - 8 * i -: 8]});
    end
  endtask
  task automatic t_actions();
    logic [7:0] cl [9] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h90, 8'h8B, 8'h8F};
    int n0;
    for (int i = 0; i < 9; i++) begin
      n0 = n_act;
      xfer({1'b0, cl[i]});
      chk(n_act - n0, 1);
      chk(last_act, cl[i]);
      chk(fb, WA);
    end
  endtask
  task automatic t_full();
    logic [8:0] fl;
    for (int p = 0; p < 2; p++) begin
      fl = (p == 0) ? 9'h1FF : 9'h000;
      @(posedge CLK);
      ev <= fl;
      @(posedge CLK);
      ev <= 9'h000;
      repeat (2) @(posedge CLK);
      #1 chk(flags, fl);
      xfer(9'h181);
      chk(fb, WA | 8'h01);
      chk_rx({SA, f[31:8], fl[5:0], f[7:6], f[5:2], fl[6], fl[7], 1'b1, fl[8],
        16'hFFFF});
      chk(flags, 9'h000);
      @(posedge CLK);
      f <= ~f;
    end
  endtask
  task automatic t_pos();
    wrr(REG_TARGET_OFS, tw(3'd3, 1'b0));
    xfer(9'h1FC);
    chk_rx({SA, ACT[15:8], ACT[7:3], 3'b000, TGT[15:8], TGT[7:3], 3'b000, SAFE[7:0],
      5'h1F, SAFE[10:8], 8'hFF});
    wrr(REG_TARGET_OFS, tw(3'd0, 1'b0));
  endtask
  task automatic t_unknown();
    int n0;
    for (int i = 0; i < 2; i++) begin
      n0 = n_act;
      xfer({1'b1, (i == 0) ? 8'h55 : OTP_PARAM_READ_CMD});
      chk(n_act - n0, 0);
      chk_rx(64'hFFFF_FFFF_FFFF_FFFF);
    end
  endtask
  task automatic t_gcall();
    int n0;
    n0 = n_act;
    wrr(REG_TARGET_OFS, tw(3'd0, 1'b1));
    xfer(9'h186);
    chk(n_act - n0, 1);
    chk(fb, 8'h00);
    wrr(REG_TARGET_OFS, tw(3'd0, 1'b0));
  endtask
  task automatic t_nack();
    logic [31:0] d;
    int n0;
    wrr(REG_IRQ_OFS, 32'h0000_0003);
    wrr(REG_TARGET_OFS, {23'h0, 3'd0, 1'b0, PIN, ~PA});
    n0 = n_act;
    xfer(9'h085);
    rdr(REG_IRQ_OFS, d);
    chk(d[1], 1'b1);
    chk(n_act - n0, 0);
    chk(irq, 1'b0);
    wrr(REG_MASK_OFS, 32'h0000_0002);
    @(posedge CLK);
    #1 chk(irq, 1'b1);
    wrr(REG_IRQ_OFS, 32'h0000_0003);
    @(posedge CLK);
    #1 chk(irq, 1'b0);
    rdr(8'h44, d);
    chk(d, 32'h0000_0000);
    wrr(REG_TARGET_OFS, tw(3'd0, 1'b0));
  endtask
  initial begin
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    wrr(REG_TARGET_OFS, tw(3'd0, 1'b0));
    t_actions();
    t_full();
    t_pos();
    t_unknown();
    t_gcall();
    t_nack();
    end_sim();
  end
endmodule
